// file: verilog/ssp_pkg.sv
// How it works
// - Pins sampled only on the rising clock edge
// - Sleep and output enable act without clock
// - Output enable off forces drivers off now
// - Writes start at edge, commit self-timed
// - Pipelined reads leave via output register
// - Pipelined and flow-through modes selectable
// - Read and write back to back, no gap
// - Double late write pipelined, single flow-through
// - Nine-bit byte lanes, each with own enable
// - Three chip selects for depth expansion
// - Sleep request enters power-down
// - Clock enable off freezes all state except the strap and sleep synchronisers
// - Selected only with all three selects active
`default_nettype none

package ssp_pkg;

   ////////////////////////////////////////////////////////////////////////
   // Geometry
   localparam int LANE_W = 9;       // Bits per byte lane
   localparam int LANES = 4;        // Byte lanes per word
   localparam int ADDR_W_DEF = 6;   // Small flip-flop array by default
   localparam int BURST_W = 2;      // Burst counter covers four beats
   localparam int WBUF_DEPTH = 2;   // Covers a queued write plus one late-write stage

   ////////////////////////////////////////////////////////////////////////
   // Burst counter constants
   localparam logic [BURST_W-1:0] BURST_ZERO = 2'h0;
   localparam logic [BURST_W-1:0] BURST_ONE = 2'h1;

   ////////////////////////////////////////////////////////////////////////
   // Operation held in the command stage, one-hot
   typedef enum logic [2:0] {
      OP_IDLE = 3'h1,
      OP_READ = 3'h2,
      OP_WRITE = 3'h4
   } ssp_op_type;

endpackage : ssp_pkg

`default_nettype wire

// file: verilog/ssp_wbuf_if.sv
`default_nettype none

// Write path between command pipeline and the storage array
interface ssp_wbuf_if #(
   parameter int W = 1
) (
   input wire logic clk,
   input wire logic srst
);
   logic in_valid;        // Word offered by the pipeline
   logic in_ready;        // Buffer has room
   logic [W-1:0] in_data; // Address, lanes and data
   logic out_valid;       // Head entry present
   logic out_ready;       // Array can take the head
   logic [W-1:0] out_data; // Head entry

   // Pipeline side
   modport src (output in_valid, output in_data, input in_ready);
   // Buffer itself
   modport fifo (
      input clk,
      input srst,
      input in_valid,
      input in_data,
      input out_ready,
      output in_ready,
      output out_valid,
      output out_data
   );
   // Array side
   modport snk (input out_valid, input out_data, output out_ready);
endinterface : ssp_wbuf_if

`default_nettype wire

// file: verilog/ssp_wbuf.sv
`default_nettype none

module ssp_wbuf #(
   parameter int W = 1,
   parameter int DEPTH = ssp_pkg::WBUF_DEPTH
) (
   // Both sides of the buffer
   ssp_wbuf_if.fifo q
);
   localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   localparam int CW = $clog2(DEPTH + 1);
   localparam logic [PW-1:0] PTR_LAST = PW'(DEPTH - 1);
   localparam logic [CW-1:0] CNT_FULL = CW'(DEPTH);

   logic [W-1:0] store_r [DEPTH]; // Entry storage in flip-flops
   logic [PW-1:0] wr_ptr_r;       // Next free slot
   logic [PW-1:0] rd_ptr_r;       // Head slot
   logic [CW-1:0] count_r;        // Entries held
   logic push_w;
   logic pop_w;

   // Honest flags straight from the count
   assign q.in_ready = (count_r != CNT_FULL);
   assign q.out_valid = (count_r != '0);
   assign q.out_data = store_r[rd_ptr_r];
   assign push_w = q.in_valid & q.in_ready;
   assign pop_w = q.out_valid & q.out_ready;

   ////////////////////////////////////////////////////////////////////////
   // Storage write, no reset needed on data
   always_ff @(posedge q.clk) begin
      if (push_w) begin
         store_r[wr_ptr_r] <= q.in_data;
      end
   end

   // Pointers wrap at the depth, not a power of two
   always_ff @(posedge q.clk) begin
      if (q.srst) begin
         wr_ptr_r <= '0;
         rd_ptr_r <= '0;
      end else begin
         if (push_w) begin
            wr_ptr_r <= (wr_ptr_r == PTR_LAST) ? '0 : wr_ptr_r + 1'b1;
         end
         if (pop_w) begin
            rd_ptr_r <= (rd_ptr_r == PTR_LAST) ? '0 : rd_ptr_r + 1'b1;
         end
      end
   end

   // Occupancy, simultaneous push and pop leaves it unchanged
   always_ff @(posedge q.clk) begin
      if (q.srst) begin
         count_r <= '0;
      end else if (push_w && !pop_w) begin
         count_r <= count_r + 1'b1;
      end else if (pop_w && !push_w) begin
         count_r <= count_r - 1'b1;
      end
   end

endmodule : ssp_wbuf

`default_nettype wire

// file: verilog/ssp_sram_port.sv
`default_nettype none

module ssp_sram_port #(
   parameter int ADDR_W = ssp_pkg::ADDR_W_DEF,
   parameter int LANES = ssp_pkg::LANES,
   localparam int DW = LANES * ssp_pkg::LANE_W
) (
   // Clock and reset
   input wire logic CLK,
   input wire logic SRST,
   // Synchronous command pins
   input wire logic CLK_ENABLE_N,
   input wire logic CHIP_SELECT_ONE_N,
   input wire logic CHIP_SELECT_TWO,
   input wire logic CHIP_SELECT_THREE_N,
   input wire logic BURST_STEP,
   input wire logic WRITE_N,
   input wire logic [LANES-1:0] LANE_STORE_N,
   input wire logic [ADDR_W-1:0] ADDR,
   // Data pins, split two-way bus
   input wire logic [DW-1:0] DQ_IN,
   output logic [DW-1:0] DQ_OUT,
   output logic DQ_OE,
   // Static straps
   input wire logic FLOW_THROUGH_SELECT,
   input wire logic BURST_ORDER_SELECT_N,
   // Asynchronous pins
   input wire logic OUTPUT_ENABLE_N,
   input wire logic SLEEP_REQUEST,
   // Status
   output logic SLEEPING
);
   localparam int LW = ssp_pkg::LANE_W;
   localparam int BW = ssp_pkg::BURST_W;
   localparam int EW = ADDR_W + LANES + DW;
   localparam int DEPTH = 2 ** ADDR_W;

   ////////////////////////////////////////////////////////////////////////
   // Declarations

   // Clock qualifier
   logic ce;
   // Two-flop synchronisers for straps and sleep
   logic ft_m_r;
   logic ft_r;
   logic lin_m_r;
   logic lin_r;
   logic slp_m_r;
   logic slp_r;
   // Pin decode
   logic sel_w;
   logic load_w;
   logic take_w;
   logic [LANES-1:0] lanes_w;
   // Command stage
   ssp_pkg::ssp_op_type op_r;
   logic [ADDR_W-1:0] addr_r;
   logic [LANES-1:0] lanes_r;
   logic [BW-1:0] base_r;
   logic [BW-1:0] cnt_r;
   logic [BW-1:0] cnt_nxt;
   logic [BW-1:0] low_nxt;
   // Second late-write stage, pipelined mode only
   logic wp_v_r;
   logic [ADDR_W-1:0] wp_addr_r;
   logic [LANES-1:0] wp_lanes_r;
   // Write buffer head
   logic push_w;
   logic pop_w;
   logic [ADDR_W-1:0] h_addr;
   logic [LANES-1:0] h_lanes;
   logic [DW-1:0] h_data;
   // Read path
   logic [DW-1:0] rd_w;
   logic [DW-1:0] q_r;
   logic qv_r;
   logic drive_w;

   // Lane slice, used for array write and forwarding
   function automatic logic [LW-1:0] lane_of(input logic [DW-1:0] word,
                                             input int idx);
      lane_of = word[idx*LW +: LW];
   endfunction : lane_of

   ////////////////////////////////////////////////////////////////////////
   // Clock enable gates every state update below except the synchronisers
   assign ce = ~CLK_ENABLE_N;

   // Straps are static, sleep is asynchronous; all pass two flops
   always_ff @(posedge CLK) begin
      if (SRST) begin
         ft_m_r <= 1'b0;
         ft_r <= 1'b0;
         lin_m_r <= 1'b0;
         lin_r <= 1'b0;
         slp_m_r <= 1'b0;
         slp_r <= 1'b0;
      end else begin
         ft_m_r <= FLOW_THROUGH_SELECT;
         ft_r <= ft_m_r;
         // Order pin assumed static, so no glitch concern
         lin_m_r <= ~BURST_ORDER_SELECT_N;
         lin_r <= lin_m_r;
         slp_m_r <= SLEEP_REQUEST;
         slp_r <= slp_m_r;
      end
   end

   // Power-down state reported to the system
   assign SLEEPING = slp_r;

   ////////////////////////////////////////////////////////////////////////
   // Pin decode

   // All three selects must be active at once
   assign sel_w = ~CHIP_SELECT_ONE_N & CHIP_SELECT_TWO
                  & ~CHIP_SELECT_THREE_N;
   // Low step means a new external address
   assign load_w = ~BURST_STEP;
   // Lane enables to active high
   assign lanes_w = ~LANE_STORE_N;

   // Write buffer carrier
   ssp_wbuf_if #(.W(EW)) wq (.clk(CLK), .srst(SRST));

   // A command slot counts only when awake and the buffer has room
   assign take_w = ce & ~slp_r & wq.in_ready;

   // Burst counter next beat
   assign cnt_nxt = cnt_r + ssp_pkg::BURST_ONE;
   // Linear adds, interleaved flips bits of the loaded address
   assign low_nxt = lin_r ? (base_r + cnt_nxt)
                          : (base_r ^ cnt_nxt);

   ////////////////////////////////////////////////////////////////////////
   // Command stage, captured at the rising edge only
   always_ff @(posedge CLK) begin
      if (SRST) begin
         op_r <= ssp_pkg::OP_IDLE;
         addr_r <= '0;
         lanes_r <= '0;
         base_r <= ssp_pkg::BURST_ZERO;
         cnt_r <= ssp_pkg::BURST_ZERO;
      end else if (take_w) begin
         lanes_r <= lanes_w;
         if (load_w) begin
            // New access; any read or write may follow any other
            if (!sel_w) begin
               op_r <= ssp_pkg::OP_IDLE;
            end else if (WRITE_N) begin
               op_r <= ssp_pkg::OP_READ;
            end else begin
               op_r <= ssp_pkg::OP_WRITE;
            end
            addr_r <= ADDR;
            base_r <= ADDR[BW-1:0];
            cnt_r <= ssp_pkg::BURST_ZERO;
         end else begin
            // Continue burst: kind kept, selects ignored
            addr_r[BW-1:0] <= low_nxt;
            cnt_r <= cnt_nxt;
         end
      end else if (ce) begin
         // Asleep or write buffer full: the slot is a no-op
         op_r <= ssp_pkg::OP_IDLE;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Late write pipeline

   // Pipelined mode waits one more edge for its data
   always_ff @(posedge CLK) begin
      if (SRST) begin
         wp_v_r <= 1'b0;
         wp_addr_r <= '0;
         wp_lanes_r <= '0;
      end else if (ce) begin
         wp_v_r <= (op_r == ssp_pkg::OP_WRITE) & ~ft_r & (|lanes_r);
         wp_addr_r <= addr_r;
         wp_lanes_r <= lanes_r;
      end
   end

   // Data taken from the pins at the second or third edge
   always_comb begin
      if (ft_r) begin
         // Single late write, aborts push nothing
         push_w = ce & (op_r == ssp_pkg::OP_WRITE) & (|lanes_r);
         wq.in_data = {addr_r, lanes_r, DQ_IN};
      end else begin
         // Double late write
         push_w = ce & wp_v_r;
         wq.in_data = {wp_addr_r, wp_lanes_r, DQ_IN};
      end
   end
   assign wq.in_valid = push_w;

   // Two entries cover flow-through; pipelined mode can hold three writes when sleep stops draining and drops the last
   ssp_wbuf #(.W(EW), .DEPTH(ssp_pkg::WBUF_DEPTH)) u_wbuf (.q(wq));

   // Array drains whenever the clock runs and the part is awake
   assign wq.out_ready = ce & ~slp_r;
   assign pop_w = wq.out_valid & wq.out_ready;
   assign h_addr = wq.out_data[EW-1 -: ADDR_W];
   assign h_lanes = wq.out_data[DW +: LANES];
   assign h_data = wq.out_data[DW-1:0];

   ////////////////////////////////////////////////////////////////////////
   // Storage, one bank per nine-bit lane
   generate
      for (genvar g = 0; g < LANES; g++) begin : g_lane
         logic [LW-1:0] bank [DEPTH]; // Lane storage

         // Commit without any external strobe
         always_ff @(posedge CLK) begin
            if (pop_w && h_lanes[g]) begin
               bank[h_addr] <= lane_of(h_data, g);
            end
         end

         // Forward a pending head so a just-written lane reads back
         always_comb begin
            if (wq.out_valid && h_lanes[g] && (h_addr == addr_r)) begin
               rd_w[g*LW +: LW] = lane_of(h_data, g);
            end else begin
               rd_w[g*LW +: LW] = bank[addr_r];
            end
         end
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////
   // Read output

   // Output register, loaded one edge after the address
   always_ff @(posedge CLK) begin
      if (SRST) begin
         q_r <= '0;
         qv_r <= 1'b0;
      end else if (ce) begin
         qv_r <= (op_r == ssp_pkg::OP_READ) & ~ft_r;
         if (op_r == ssp_pkg::OP_READ) begin
            q_r <= rd_w;
         end
      end
   end

   // Mode picks registered or flow-through data
   assign DQ_OUT = ft_r ? rd_w : q_r;
   assign drive_w = ft_r ? (op_r == ssp_pkg::OP_READ) : qv_r;

   // Enable and sleep pins override without waiting for a clock
   assign DQ_OE = drive_w & ~OUTPUT_ENABLE_N
                  & ~SLEEP_REQUEST;

   ////////////////////////////////////////////////////////////////////////
   // Assertions
   default clocking cb @(posedge CLK);
   endclocking
   default disable iff (SRST);

   // Pipelined write accepted with lanes
   sequence s_pipe_wr;
      take_w && load_w && sel_w && !WRITE_N && !ft_r && (|lanes_w);
   endsequence
   // Flow-through write accepted with lanes
   sequence s_ft_wr;
      take_w && load_w && sel_w && !WRITE_N && ft_r && (|lanes_w);
   endsequence

   property p_dlw;
      s_pipe_wr ##1 ce [*2] |-> push_w;
   endproperty
   a_dlw: assert property (p_dlw)
      else $error("pipelined write data not taken at third edge");

   property p_slw;
      s_ft_wr ##1 ce |-> push_w;
   endproperty
   a_slw: assert property (p_slw)
      else $error("flow-through write data not taken at second edge");

   property p_pipe_rd;
      ce && (op_r == ssp_pkg::OP_READ) && !ft_r
      |=> qv_r && (q_r == $past(rd_w));
   endproperty
   a_pipe_rd: assert property (p_pipe_rd)
      else $error("output register missed read data");

   property p_oe;
      OUTPUT_ENABLE_N |-> !DQ_OE;
   endproperty
   a_oe: assert property (p_oe)
      else $error("drivers on while output enable is off");

   property p_sleep_oe;
      SLEEP_REQUEST |-> !DQ_OE;
   endproperty
   a_sleep_oe: assert property (p_sleep_oe)
      else $error("drivers on during sleep request");

   property p_hold;
      // No drain in the frozen cycle itself; state unchanged one edge on
      !ce |-> !pop_w ##1 ($stable(addr_r) && $stable(op_r) && $stable(q_r));
   endproperty
   a_hold: assert property (p_hold)
      else $error("state moved with clock enable off");

   property p_desel;
      take_w && load_w && !sel_w |=> op_r == ssp_pkg::OP_IDLE;
   endproperty
   a_desel: assert property (p_desel)
      else $error("access started while deselected");

   property p_turn;
      (op_r == ssp_pkg::OP_READ) && take_w && load_w && sel_w && !WRITE_N
      |=> op_r == ssp_pkg::OP_WRITE;
   endproperty
   a_turn: assert property (p_turn)
      else $error("write after read not accepted at once");

   property p_lin;
      take_w && !load_w && lin_r
      |=> addr_r[BW-1:0] == $past(addr_r[BW-1:0]) + ssp_pkg::BURST_ONE;
   endproperty
   a_lin: assert property (p_lin)
      else $error("linear burst did not advance by one");

   property p_sleep_idle;
      // Drain may resume at once on wake, so no pop is checked now only
      ce && slp_r |-> !pop_w ##1 (op_r == ssp_pkg::OP_IDLE);
   endproperty
   a_sleep_idle: assert property (p_sleep_idle)
      else $error("activity during power-down");

endmodule : ssp_sram_port

`default_nettype wire

// file: dv/ssp_host_model.sv
`default_nettype none

// Controller side: one request per slot becomes pin levels
module ssp_host_model (
   // Clock and request
   input wire logic clk,
   input wire logic [1:0] kind,
   input wire logic [5:0] addr,
   input wire logic [35:0] data,
   input wire logic [3:0] lanes,
   // Straps chosen by the bench
   input wire logic flow,
   input wire logic order_n,
   // Device pins
   output logic cs1_n,
   output logic cs2,
   output logic cs3_n,
   output logic step,
   output logic wr_n,
   output logic [3:0] lane_n,
   output logic [5:0] adr,
   output logic [35:0] dq,
   output logic fts,
   output logic bos_n
);
   logic last_wr_r = 1'b0; // Burst in flight is a write
   logic wv1_r = 1'b0; // Data stage one holds write data
   logic [35:0] d1_r = 36'h0; // Data one edge after command
   logic [35:0] d2_r = 36'h0; // Data two edges after command
   logic wslot; // This slot carries write data

   ////////////////////////////////////////////////////////////////////
   // Pins follow the request; deselect drops one select
   assign wslot = kind == 2'h2 || (kind == 2'h3 && last_wr_r);
   assign fts = flow;
   assign bos_n = order_n;
   assign cs1_n = kind == 2'h0 && addr[1:0] == 2'h0;
   assign cs2 = !(kind == 2'h0 && addr[1:0] == 2'h1);
   assign cs3_n = kind == 2'h0 && addr[1];
   assign step = kind == 2'h3;
   assign wr_n = kind != 2'h2;
   assign lane_n = lanes;
   assign adr = addr;

   ////////////////////////////////////////////////////////////////////
   // Late data; idle bus toggles so stale data never looks valid
   always_ff @(posedge clk) begin
      last_wr_r <= wslot;
      wv1_r <= wslot;
      d1_r <= wslot ? data : ~d1_r;
      d2_r <= wv1_r ? d1_r : ~d2_r;
   end
   assign dq = flow ? d1_r : d2_r;
endmodule : ssp_host_model

`default_nettype wire

// file: dv/sync_sram_port_pipe_flow_bench.sv
`default_nettype none

module sync_sram_port_pipe_flow_bench;
   timeunit 1ns;
   timeprecision 100ps;
   logic clk, srst, cke_n, oe_n, slp, fl, om; // Bench-driven pins
   logic cs1_n, cs2, cs3_n, step, wr_n, fts, bos_n, dq_oe, sleeping;
   logic [3:0] lane_n, lanes; // Lane enables
   logic [5:0] adr, addr; // Pin and request address
   logic [35:0] dq_in, dq_out, data; // Data paths
   logic [1:0] kind; // Request kind
   logic [35:0] exp_m [64]; // Expected storage
   logic cv [3]; // Read expected, by age
   logic [35:0] cd [3]; // Expected read data, by age
   int rw [4]; // Recent write addresses
   int lk, bn, cut, n_mismatch, comparisons;
   logic [5:0] bb; // Burst base

   ssp_sram_port #(.ADDR_W(6), .LANES(4)) dut_u (.CLK(clk), .SRST(srst),
      .CLK_ENABLE_N(cke_n), .CHIP_SELECT_ONE_N(cs1_n),
      .CHIP_SELECT_TWO(cs2), .CHIP_SELECT_THREE_N(cs3_n),
      .BURST_STEP(step), .WRITE_N(wr_n), .LANE_STORE_N(lane_n),
      .ADDR(adr), .DQ_IN(dq_in), .DQ_OUT(dq_out), .DQ_OE(dq_oe),
      .FLOW_THROUGH_SELECT(fts), .BURST_ORDER_SELECT_N(bos_n),
      .OUTPUT_ENABLE_N(oe_n), .SLEEP_REQUEST(slp), .SLEEPING(sleeping));
   ssp_host_model host_u (.clk(clk), .kind(kind), .addr(addr),
      .data(data), .lanes(lanes), .flow(fl), .order_n(om),
      .cs1_n(cs1_n), .cs2(cs2), .cs3_n(cs3_n), .step(step),
      .wr_n(wr_n), .lane_n(lane_n), .adr(adr), .dq(dq_in), .fts(fts),
      .bos_n(bos_n));

   always #2.5 clk = ~clk;

   ////////////////////////////////////////////////////////////////////
   // Expectation helpers
   function automatic logic [35:0] merge(input logic [35:0] o,
      input logic [35:0] n, input logic [3:0] ln);
      for (int i = 0; i < 4; i++) begin
         if (!ln[i]) o[9*i +: 9] = n[9*i +: 9];
      end
      return o;
   endfunction : merge
   // Burst beats move only the two low address bits
   function automatic logic [5:0] baddr(input logic [5:0] b, input int n);
      logic [1:0] s;
      s = 2'(n);
      return {b[5:2], om ? b[1:0] ^ s : b[1:0] + s};
   endfunction : baddr
   function automatic logic [35:0] rnd();
      return {4'($urandom), $urandom};
   endfunction : rnd
   task automatic check(input string nm, input logic [35:0] e,
      input logic [35:0] g);
      comparisons++;
      if (g !== e) begin
         n_mismatch++;
         $display("Error %s expected %h seen %h", nm, e, g);
      end
   endtask : check
   task automatic results();
      $display("checks %0d mismatches %0d", comparisons, n_mismatch);
      if (n_mismatch == 0 && comparisons > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask : results

   ////////////////////////////////////////////////////////////////////
   // One bus slot: age reads, check the due one, issue the next
   task automatic slot(input logic [1:0] k, input logic [5:0] a,
      input logic [35:0] d, input logic [3:0] ln);
      logic [5:0] e;
      logic rd, wr;
      int ix;
      @(negedge clk);
      cv[2] = cv[1];
      cd[2] = cd[1];
      cv[1] = cv[0];
      cd[1] = cd[0];
      ix = fl ? 1 : 2;
      check("DQ_OE", 36'(cv[ix]), 36'(dq_oe));
      if (cv[ix]) check("DQ_OUT", cd[ix], dq_out);
      if (k == 2'h3) bn++;
      else begin
         bb = a;
         bn = 0;
      end
      e = baddr(bb, bn);
      rd = k == 2'h1 || (k == 2'h3 && lk == 1);
      // Reads close behind a write to the same word are skipped
      if (rd && (rw[0] == e || rw[1] == e || rw[2] == e || rw[3] == e))
      begin
         k = 2'h0;
         rd = 1'b0;
      end
      wr = k == 2'h2 || (k == 2'h3 && lk == 2);
      rw[3] = rw[2];
      rw[2] = rw[1];
      rw[1] = rw[0];
      rw[0] = wr ? e : -1;
      cv[0] = rd;
      cd[0] = exp_m[e];
      if (wr) exp_m[e] = merge(exp_m[e], d, ln);
      if (k != 2'h3) lk = k;
      kind = k;
      addr = a;
      data = d;
      lanes = ln;
      // Pulse an async pin after the command pins have moved; sleep is
      // too short for its synchroniser, the enable spans the rising edge
      if (cut == 1 || cut == 2) begin
         if (cut == 1) oe_n = 1'b1;
         else slp = 1'b1;
         #1;
         check("DQ_OE cut", 36'h0, 36'(dq_oe));
         slp = 1'b0;
         #2;
         oe_n = 1'b0;
      end
   endtask : slot

   task automatic do_reset();
      @(negedge clk);
      srst = 1'b1;
      for (int i = 0; i < 3; i++) cv[i] = 1'b0;
      for (int i = 0; i < 4; i++) rw[i] = -1;
      lk = 0;
      kind = 2'h0;
      repeat (10) @(negedge clk);
      srst = 1'b0;
      repeat (3) slot(2'h0, 6'h0, 36'h0, 4'hf);
   endtask : do_reset

   ////////////////////////////////////////////////////////////////////
   // Main sequence, pipelined linear then flow interleaved
   initial begin
      clk = 0;
      srst = 1;
      cke_n = 0;
      oe_n = 0;
      slp = 0;
      fl = 0;
      om = 0;
      kind = 0;
      addr = 0;
      data = 0;
      lanes = 4'hf;
      cut = 0;
      n_mismatch = 0;
      comparisons = 0;
      bn = 0;
      bb = 0;
      void'($urandom(32'h01714bcf));
      for (int p = 0; p < 2; p++) begin
         fl = 1'(p);
         om = 1'(p);
         do_reset();
         if (p == 0) for (int a = 0; a < 64; a++) slot(2, 6'(a), rnd(), 0);
         for (int i = 0; i < 250; i++) begin
            int r;
            r = $urandom % 8;
            cut = $urandom % 8;
            slot(r == 0 ? 0 : r < 4 ? 1 : r < 7 ? 2 : lk != 0 ? 3 : 1,
               6'($urandom), rnd(), r == 6 ? 4'hf : 4'($urandom));
         end
         cut = 0;
         $display("test random done");
         for (int n = 0; n < 4; n++) slot(n == 0 ? 2 : 3, 6'h17, rnd(), 0);
         repeat (4) slot(0, 0, 0, 4'hf);
         for (int n = 0; n < 4; n++) slot(n == 0 ? 1 : 3, 6'h17, 0, 4'hf);
         $display("test burst done");
         slot(1, 6'h09, 0, 4'hf);
         // Flow data stands only while the read sits in the command stage
         if (!fl) slot(0, 0, 0, 4'hf);
         slot(0, 0, 0, 4'hf);
         cke_n = 1'b1;
         repeat (3) begin
            int fx;
            @(negedge clk);
            fx = fl ? 1 : 2;
            check("DQ_OE held", 36'(cv[fx]), 36'(dq_oe));
            if (cv[fx]) check("DQ_OUT held", cd[fx], dq_out);
         end
         cke_n = 1'b0;
         $display("test freeze done");
         slp = 1'b1;
         repeat (4) slot(0, 0, 0, 4'hf);
         check("SLEEPING", 36'h1, 36'(sleeping));
         begin
            logic [35:0] old;
            old = exp_m[6'h2a];
            slot(2, 6'h2a, ~old, 0);
            exp_m[6'h2a] = old;
         end
         slot(0, 0, 0, 4'hf);
         slp = 1'b0;
         repeat (4) slot(0, 0, 0, 4'hf);
         check("SLEEPING", 36'h0, 36'(sleeping));
         slot(1, 6'h2a, 0, 4'hf);
         repeat (3) slot(0, 0, 0, 4'hf);
         $display("test sleep done");
      end
      results();
   end

   // Watchdog: the run needs about 660 cycles
   initial begin
      #100000;
      n_mismatch++;
      $display("Error watchdog expected done seen hang");
      results();
   end
endmodule : sync_sram_port_pipe_flow_bench

`default_nettype wire
